/* File: bench/fpcmp_issue_model.sv */
// Purpose: Issue logic and register file port facing the compare unit
// Assumes: Requests change right after a rising edge and hold until sampled
// Notes:   Released source lines carry the inverse of the last word
`timescale 1ns/1ps
module fpcmp_issue_model
  import fpcmp_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        unit_busy,
  input  wire logic        dst_we,
  input  wire logic [31:0] dst_data,
  output logic             issue_valid,
  output logic [1:0]       issue_op,
  output logic             issue_pred,
  output logic [31:0]      src1_word,
  output logic [31:0]      src2_word
);
  // Idle request lines at time zero
  initial begin
    issue_valid = 1'b0;
    issue_op    = 2'h0;
    issue_pred  = 1'b0;
    src1_word   = 32'h0;
    src2_word   = 32'h0;
  end

  // One compare on the shift unit; result latency counted in edges after the last read
  task automatic issue(input logic [1:0] op, input logic pred, input logic [63:0] a,
                       input logic [63:0] b, output int cyc, output logic [31:0] res,
                       output logic bsy);
    res = 32'h0;
    cyc = -1;
    @(posedge pclk);
    issue_valid <= 1'b1;
    issue_op    <= op;
    issue_pred  <= pred;
    src1_word   <= a[31:0];
    src2_word   <= b[31:0];
    @(posedge pclk);
    issue_valid <= 1'b0; // No new issue during the high-word cycle
    if (op[1]) begin
      src1_word <= a[63:32];
      src2_word <= b[63:32];
      @(posedge pclk);
    end
    bsy = unit_busy;
    src1_word <= ~src1_word;
    src2_word <= ~src2_word;
    for (int k = 1; k <= 3 && cyc < 0; k++) begin
      @(posedge pclk);
      if (dst_we === 1'b1) begin
        cyc = k;
        res = dst_data;
      end
    end
  endtask
endmodule

/* File: bench/fpcmp_unit_bench.sv */
// Purpose: Self-checking bench of the compare unit against a behavioural model
// Assumes: APB master holds each request until pready is sampled
// Notes:   Special operands swept for all four operations, then random ones
`timescale 1ns/1ps
`define FC_CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected %s expected %0h seen %0h", nm, e, g); end end
module fpcmp_unit_bench;
  import fpcmp_pkg::*;
  logic pclk, presetn, issue_valid, issue_pred, unit_busy, dst_we, irq;
  logic psel, penable, pwrite, pready, pslverr;
  logic [1:0]  issue_op;
  logic [3:0]  pstrb;
  logic [5:0]  status_flags, exp_stat;
  logic [7:0]  paddr;
  logic [31:0] src1_word, src2_word, dst_data, pwdata, prdata;
  int n_fail = 0, tests_run = 0, n_exec = 0, seed = 32'h2FBED0C9;
  bit last = 1'b0;
  logic [31:0] sv [9] = '{32'h7F800000, 32'hFF800000, 32'h7FC00000, 32'h00000001,
    32'h80000001, 32'h00000000, 32'h80000000, 32'h4109999A, 32'hC0200000};
  logic [63:0] dv [9] = '{64'h7FF0000000000000, 64'hFFF0000000000000,
    64'h7FF8000000000000, 64'h1, 64'h8000000000000001, 64'h0,
    64'h8000000000000000, 64'h4021333333333333, 64'hC004000000000000};

  fpcmp_unit dut_u (.pclk(pclk), .presetn(presetn), .issue_valid(issue_valid),
    .issue_op(issue_op), .issue_pred(issue_pred), .src1_word(src1_word),
    .src2_word(src2_word), .unit_busy(unit_busy), .dst_we(dst_we), .dst_data(dst_data),
    .status_flags(status_flags), .irq(irq), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  fpcmp_issue_model pm_u (.pclk(pclk), .unit_busy(unit_busy), .dst_we(dst_we),
    .dst_data(dst_data), .issue_valid(issue_valid), .issue_op(issue_op),
    .issue_pred(issue_pred), .src1_word(src1_word), .src2_word(src2_word));

  // Clock at 125 MHz
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // Ordering key: denormals fold to signed zero, both zeros give one key
  function automatic longint key(input logic [63:0] v, input bit dbl, output bit nan,
                                 output bit den);
    logic [62:0] mag;
    bit ex1, ex0;
    mag = dbl ? v[62:0] : {32'h0, v[30:0]};
    ex1 = dbl ? &v[62:52] : &v[30:23];
    ex0 = dbl ? ~|v[62:52] : ~|v[30:23];
    nan = ex1 && (dbl ? |v[51:0] : |v[22:0]);
    den = ex0 && (mag != '0);
    if (ex0) mag = '0;
    key = v[dbl ? 63 : 31] ? -longint'(mag) : longint'(mag);
  endfunction

  // APB transfer: setup, access, wait for pready
  task automatic apb(input bit wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // One compare checked against the model
  task automatic run(input logic [1:0] op, input bit pred, input logic [63:0] a,
                     input logic [63:0] b);
    logic [31:0] got;
    logic bsy;
    int cyc;
    bit n1, n2, d1, d2, r;
    longint k1, k2;
    k1 = key(a, op[1], n1, d1);
    k2 = key(b, op[1], n2, d2);
    r = !(n1 | n2) && (op[0] ? k1 < k2 : k1 > k2);
    pm_u.issue(op, pred, a, b, cyc, got, bsy);
    if (pred) begin
      exp_stat |= {d2, d1, n2, n1, n1 | n2, n1 | n2};
      n_exec++;
      last = r;
      `FC_CHK("result", {31'h0, r}, got)
    end
    `FC_CHK("latency", pred ? 1 : -1, cyc)
    `FC_CHK("busy", op[1], bsy)
    `FC_CHK("status", exp_stat, status_flags)
  endtask

  // Verdict and end of run
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Watchdog
  initial begin
    #500000;
    n_fail++;
    final_report();
  end

  // Main sequence
  initial begin
    logic [31:0] rd;
    logic err;
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h0; pwdata = 32'h0;
    pstrb = 4'hF; presetn = 1'b0; exp_stat = 6'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0, rd, err);
      `FC_CHK("reset value", FPCMP_RST_WORD, rd)
    end
    for (int op = 0; op < 4; op++)
      for (int i = 0; i < 9; i++)
        for (int j = 0; j < 9; j++)
          run(2'(op), 1'b1, op[1] ? dv[i] : {32'h0, sv[i]}, op[1] ? dv[j] : {32'h0, sv[j]});
    // Interrupt: masked, unmasked, then cleared by write-one
    `FC_CHK("irq masked", 1'b0, irq)
    apb(1'b1, FPCMP_OFF_MASK, 32'h1, rd, err);
    apb(1'b0, FPCMP_OFF_MASK, 32'h0, rd, err);
    `FC_CHK("mask readback", 32'h1, rd)
    `FC_CHK("irq", exp_stat[0], irq)
    apb(1'b1, FPCMP_OFF_STATUS, 32'h3F, rd, err);
    exp_stat = 6'h0;
    apb(1'b0, FPCMP_OFF_STATUS, 32'h0, rd, err);
    `FC_CHK("cleared", 32'h0, rd)
    `FC_CHK("irq cleared", 1'b0, irq)
    for (int k = 0; k < 4; k++) run(2'(k), 1'b0, dv[2], dv[3]);
    for (int k = 0; k < 200; k++) begin
      logic [63:0] a, b;
      a = {$random(seed), $random(seed)};
      b = (k % 8 == 0) ? a : {$random(seed), $random(seed)};
      run(2'($random(seed)), ($random(seed) & 3) != 0, a, b);
    end
    apb(1'b0, FPCMP_OFF_RESULT, 32'h0, rd, err);
    `FC_CHK("last result", {31'h0, last}, rd)
    apb(1'b0, FPCMP_OFF_COUNT, 32'h0, rd, err);
    `FC_CHK("count", 32'(n_exec), rd)
    apb(1'b0, 8'h10, 32'h0, rd, err);
    `FC_CHK("unmapped error", 1'b1, err)
    `FC_CHK("unmapped data", 32'h0, rd)
    final_report();
  end
endmodule

/* File: core/fpcmp_classify.sv */
// Purpose: Classify one IEEE operand and map it to an ordering key
// Assumes: Combinational; operand given as a 64-bit double or a single in the low word
// Notes:   Denormals fold to zero; both zeros give one key
`timescale 1ns/1ps
module fpcmp_classify
  import fpcmp_pkg::*;
(
  input  wire logic [63:0] operand,
  input  wire logic        is_double,
  output logic             is_nan,
  output logic             is_denorm,
  output logic [63:0]      order_key
);
  logic        sign;
  logic        exp_max;
  logic        exp_zero;
  logic        frac_zero;
  logic [63:0] mag;

  // Field extraction for both widths, single magnitude zero-extended in the low bits
  always_comb begin
    if (is_double) begin
      sign      = operand[63];
      exp_max   = &operand[62:52];
      exp_zero  = ~|operand[62:52];
      frac_zero = ~|operand[51:0];
      mag       = {1'b0, operand[62:0]};
    end else begin
      sign      = operand[31];
      exp_max   = &operand[30:23];
      exp_zero  = ~|operand[30:23];
      frac_zero = ~|operand[22:0];
      mag       = {33'h0_0000_0000, operand[30:0]};
    end
    is_nan    = exp_max & ~frac_zero;
    is_denorm = exp_zero & ~frac_zero;
    // Signed zero and denormals become magnitude zero
    if (exp_zero) begin
      mag = 64'h0000_0000_0000_0000;
    end
    // Monotonic key: negatives inverted, positives offset by the top bit
    if (mag == 64'h0000_0000_0000_0000) begin
      order_key = 64'h8000_0000_0000_0000;
    end else if (sign) begin
      // Negatives stay below the zero key; a larger magnitude gives a smaller key
      order_key = {1'b0, ~mag[62:0]};
    end else begin
      order_key = mag | 64'h8000_0000_0000_0000;
    end
  end
endmodule

/* File: core/fpcmp_pkg.sv */
// Purpose: Shared constants and types for the ordered floating-point compare unit
// Assumes: 32-bit APB data, one aligned word per register
// Notes:   Register offsets are byte addresses
package fpcmp_pkg;

  // Register map
  localparam logic [7:0] FPCMP_OFF_STATUS = 8'h00;
  localparam logic [7:0] FPCMP_OFF_MASK   = 8'h04;
  localparam logic [7:0] FPCMP_OFF_RESULT = 8'h08;
  localparam logic [7:0] FPCMP_OFF_COUNT  = 8'h0C;

  // Status field positions
  localparam int FPCMP_BIT_UNORDERED_FLAG = 0;
  localparam int FPCMP_BIT_INVALID_OPERATION_FLAG = 1;
  localparam int FPCMP_BIT_NAN1  = 2;
  localparam int FPCMP_BIT_NAN2  = 3;
  localparam int FPCMP_BIT_DEN1  = 4;
  localparam int FPCMP_BIT_DEN2  = 5;
  localparam int FPCMP_STAT_W    = 6;

  // Reset values
  localparam logic [5:0]  FPCMP_RST_STATUS = 6'h00;
  localparam logic [5:0]  FPCMP_RST_MASK   = 6'h00;
  localparam logic [31:0] FPCMP_RST_WORD   = 32'h0000_0000;

  // Cycle counts of the two operation kinds
  localparam int FPCMP_SP_CYCLES = 1;
  localparam int FPCMP_DP_CYCLES = 2;

  // Operation code on the issue port
  typedef enum logic [1:0] {
    FPCMP_OP_SGT,
    FPCMP_OP_SLT,
    FPCMP_OP_DGT,
    FPCMP_OP_DLT
  } fpcmp_op_e;

  typedef enum logic [0:0] {
    FPCMP_ST_IDLE,
    FPCMP_ST_HIGH
  } fpcmp_state_e;

endpackage

/* File: core/fpcmp_unit.sv */
// Purpose: Ordered greater/less compare of single and double floats
// Assumes: Issue logic holds pred and sources per stage; APB master per protocol
// Notes:   One-cycle APB answer; status set wins over write-one-clear
// Function
// RULE_01 - Write 1 if relation holds, else 0
// RULE_02 - False predicate: no result, no flags
// RULE_03 - NaN source: result 0, unordered and invalid
// RULE_04 - Touch only the compare status flags
// RULE_05 - Flag NaN or denormal per source
// RULE_06 - Double: low E1, high E2, write E2
// RULE_07 - Single: read and write in E1
// RULE_08 - Greater: +inf wins, zeros/denormals give 0
// RULE_09 - Less: -inf wins, zeros/denormals give 0
// RULE_10 - Issue only to shift units, cross path allowed
// RULE_11 - Double operand is odd/even pair, 32-bit result
// RULE_12 - Denormal compares as signed zero, flags it
`timescale 1ns/1ps
module fpcmp_unit
  import fpcmp_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        issue_valid,
  input  wire logic [1:0]  issue_op,
  input  wire logic        issue_pred,
  input  wire logic [31:0] src1_word,
  input  wire logic [31:0] src2_word,
  output logic             unit_busy,
  output logic             dst_we,
  output logic [31:0]      dst_data,
  output logic [5:0]       status_flags,
  output logic             irq,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);

  typedef struct packed {
    fpcmp_state_e state;
    logic         less;
    logic         pred;
    logic [31:0]  src1_lo;
    logic [31:0]  src2_lo;
    logic         busy;
    logic         we;
    logic [31:0]  result;
    logic [5:0]   status;
    logic [5:0]   mask;
    logic [31:0]  count;
    logic         irq;
    logic [31:0]  rdata;
    logic         ready;
    logic         err;
  } fpcmp_regs_s;

  fpcmp_regs_s r;
  fpcmp_regs_s next_r;

  logic        op_double;
  logic        op_less;
  logic        fire;
  logic        fire_pred;
  logic [63:0] opnd1;
  logic [63:0] opnd2;
  logic        cls_double;
  logic        nan1;
  logic        nan2;
  logic        den1;
  logic        den2;
  logic [63:0] key1;
  logic [63:0] key2;
  logic        cmp_less;
  logic        cmp_result;
  logic [5:0]  set_bits;
  logic        apb_acc;
  logic        mapped;

  // Operand assembly: single uses current words, double pairs high with held low
  always_comb begin
    op_double  = issue_op[1];
    op_less    = issue_op[0];
    fire       = 1'b0;
    fire_pred  = 1'b0;
    cls_double = 1'b0;
    opnd1      = {32'h0000_0000, src1_word};
    opnd2      = {32'h0000_0000, src2_word};
    cmp_less   = op_less;
    if (r.state == FPCMP_ST_HIGH) begin
      fire       = 1'b1;                                 // [RULE_06]
      fire_pred  = r.pred;
      cls_double = 1'b1;
      cmp_less   = r.less;
      opnd1      = {src1_word, r.src1_lo};               // [RULE_11]
      opnd2      = {src2_word, r.src2_lo};
    end else if (issue_valid && !op_double) begin
      fire      = 1'b1;                                  // [RULE_07]
      fire_pred = issue_pred;
    end
  end

  fpcmp_classify u_cls1 (
    .operand   (opnd1),
    .is_double (cls_double),
    .is_nan    (nan1),
    .is_denorm (den1),
    .order_key (key1)
  );

  fpcmp_classify u_cls2 (
    .operand   (opnd2),
    .is_double (cls_double),
    .is_nan    (nan2),
    .is_denorm (den2),
    .order_key (key2)
  );

  // Relation on ordering keys; denormals already folded to zero
  always_comb begin
    if (nan1 || nan2) begin
      cmp_result = 1'b0;                                 // [RULE_03]
    end else if (cmp_less) begin
      cmp_result = key1 < key2;                          // [RULE_09] [RULE_12]
    end else begin
      cmp_result = key1 > key2;                          // [RULE_08] [RULE_12]
    end
    set_bits                  = 6'h00;
    set_bits[FPCMP_BIT_UNORDERED_FLAG] = nan1 | nan2;             // [RULE_03]
    set_bits[FPCMP_BIT_INVALID_OPERATION_FLAG] = nan1 | nan2;
    set_bits[FPCMP_BIT_NAN1]  = nan1;                    // [RULE_05]
    set_bits[FPCMP_BIT_NAN2]  = nan2;
    set_bits[FPCMP_BIT_DEN1]  = den1;                    // [RULE_12]
    set_bits[FPCMP_BIT_DEN2]  = den2;
  end

  assign apb_acc = psel & penable;
  assign mapped  = (paddr == FPCMP_OFF_STATUS) || (paddr == FPCMP_OFF_MASK) ||
                   (paddr == FPCMP_OFF_RESULT) || (paddr == FPCMP_OFF_COUNT);

  // Next-state logic: sequencer, result, status, APB slave
  always_comb begin
    next_r       = r;
    next_r.we    = 1'b0;
    next_r.ready = 1'b0;
    next_r.err   = 1'b0;
    next_r.busy  = 1'b0;
    case (r.state)
      FPCMP_ST_IDLE: begin
        if (issue_valid && op_double) begin
          next_r.state   = FPCMP_ST_HIGH;                // [RULE_06]
          next_r.less    = op_less;
          next_r.pred    = issue_pred;
          next_r.src1_lo = src1_word;
          next_r.src2_lo = src2_word;
          next_r.busy    = 1'b1;
        end
      end
      FPCMP_ST_HIGH: begin
        next_r.state = FPCMP_ST_IDLE;
      end
      default: begin
        next_r.state = FPCMP_ST_IDLE;
      end
    endcase
    // Software write-one-clear, then hardware set wins
    if (apb_acc && !r.ready && pwrite && pstrb[0]) begin
      if (paddr == FPCMP_OFF_STATUS) begin
        next_r.status = r.status & ~pwdata[5:0];
      end else if (paddr == FPCMP_OFF_MASK) begin
        next_r.mask = pwdata[5:0];
      end
    end
    if (fire && fire_pred) begin                         // [RULE_02]
      next_r.we     = 1'b1;                              // [RULE_01]
      next_r.result = {31'h0000_0000, cmp_result};
      next_r.status = next_r.status | set_bits;          // [RULE_04]
      next_r.count  = r.count + 32'h0000_0001;
    end
    // APB access phase answered one cycle after it starts
    if (apb_acc && !r.ready) begin
      next_r.ready = 1'b1;
      next_r.err   = !mapped;
      next_r.rdata = 32'h0000_0000;
      if (!pwrite) begin
        case (paddr)
          FPCMP_OFF_STATUS: next_r.rdata = {26'h000_0000, r.status};
          FPCMP_OFF_MASK:   next_r.rdata = {26'h000_0000, r.mask};
          FPCMP_OFF_RESULT: next_r.rdata = r.result;
          FPCMP_OFF_COUNT:  next_r.rdata = r.count;
          default:          next_r.rdata = 32'h0000_0000;
        endcase
      end
    end
    next_r.irq = |(next_r.status & next_r.mask);
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r         <= '0;
      r.state   <= FPCMP_ST_IDLE;
      r.status  <= FPCMP_RST_STATUS;
      r.mask    <= FPCMP_RST_MASK;
      r.result  <= FPCMP_RST_WORD;
      r.count   <= FPCMP_RST_WORD;
    end else begin
      r <= next_r;
    end
  end

  assign unit_busy    = r.busy;
  assign dst_we       = r.we;
  assign dst_data     = r.result;
  assign status_flags = r.status;
  assign irq          = r.irq;
  assign prdata       = r.rdata;
  assign pready       = r.ready;
  assign pslverr      = r.err;

  // Checks
  AST_SP_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    (r.state == FPCMP_ST_IDLE && issue_valid && !issue_op[1] && issue_pred)
      |=> dst_we) else $error("single compare did not write"); // [RULE_07]
  AST_DP_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    (r.state == FPCMP_ST_IDLE && issue_valid && issue_op[1] && issue_pred)
      |=> !dst_we ##1 dst_we) else $error("double compare write timing"); // [RULE_06]
  AST_PRED_NOP: assert property (@(posedge pclk) disable iff (!presetn)
    (fire && !fire_pred) |=> !dst_we && $stable(status_flags))
    else $error("false predicate changed state"); // [RULE_02]
  AST_NAN_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    (fire && fire_pred && (nan1 || nan2)) |=> dst_data == 32'h0000_0000 &&
      status_flags[FPCMP_BIT_UNORDERED_FLAG] && status_flags[FPCMP_BIT_INVALID_OPERATION_FLAG])
    else $error("nan compare wrong"); // [RULE_03]
  AST_RESULT_01: assert property (@(posedge pclk) disable iff (!presetn)
    dst_we |-> dst_data[31:1] == 31'h0000_0000)
    else $error("result not 0 or 1"); // [RULE_01]
  AST_SRC_FLAGS: assert property (@(posedge pclk) disable iff (!presetn)
    (fire && fire_pred && den1) |=> status_flags[FPCMP_BIT_DEN1])
    else $error("denormal flag missing"); // [RULE_05]
  AST_ZERO_GT: assert property (@(posedge pclk) disable iff (!presetn)
    (fire && fire_pred && key1 == key2) |=> dst_data == 32'h0000_0000)
    else $error("equal operands gave true"); // [RULE_08]
  AST_LT_POSINF: assert property (@(posedge pclk) disable iff (!presetn)
    (fire && fire_pred && cmp_less && key1 >= key2) |=> dst_data == 32'h0000_0000)
    else $error("less-than wrong"); // [RULE_09]
  AST_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
    irq == |(status_flags & r.mask)) else $error("irq mismatch"); // [RULE_04]
  COV_SP: cover property (@(posedge pclk) disable iff (!presetn) dst_we && !unit_busy);
  COV_DP: cover property (@(posedge pclk) disable iff (!presetn) unit_busy ##1 dst_we);
  COV_NAN: cover property (@(posedge pclk) disable iff (!presetn)
    status_flags[FPCMP_BIT_UNORDERED_FLAG]);
  COV_IRQ: cover property (@(posedge pclk) disable iff (!presetn) irq);

endmodule
